// ### hw/nfc_pkg.sv
// Shared constants and types of the NAND flash host controller
package nfc_pkg;

	// ************************************************************
	// Clock and pin timing
	// ************************************************************
	localparam int CLK_PERIOD_NS = 50;
	localparam int SYNC_STAGES   = 2;
	localparam int T_SETUP_NS    = 50;
	localparam int T_WLOW_NS     = 50;
	localparam int T_RLOW_NS     = 100;
	localparam int T_HOLD_NS     = 50;
	localparam int T_WB_NS       = 200;

	// Least times, rounded up to whole cycles; read low time adds the synchroniser stages
	localparam logic [3:0] SETUP_CYC =
		4'((T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WLOW_CYC =
		4'((T_WLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] RLOW_CYC =
		4'((T_RLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + SYNC_STAGES);
	localparam logic [3:0] HOLD_CYC =
		4'((T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] WB_CYC =
		4'((T_WB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

	// ************************************************************
	// Device command codes
	// ************************************************************
	localparam logic [7:0] CMD_READ_LO    = 8'h00;
	localparam logic [7:0] CMD_READ_HI    = 8'h01;
	localparam logic [7:0] CMD_READ_SPARE = 8'h50;
	localparam logic [7:0] CMD_SER_IN     = 8'h80;
	localparam logic [7:0] CMD_PROG_GO    = 8'h10;
	localparam logic [7:0] CMD_ERASE_SET  = 8'h60;
	localparam logic [7:0] CMD_ERASE_GO   = 8'hD0;
	localparam logic [7:0] CMD_STATUS     = 8'h70;
	localparam logic [7:0] CMD_ID         = 8'h90;
	localparam logic [7:0] CMD_RESET      = 8'hFF;
	localparam logic [7:0] ID_ADDR        = 8'h00;

	// Status byte fields
	localparam int ST_FAIL_BIT  = 0;
	localparam int ST_READY_BIT = 6;
	localparam int ST_WP_BIT    = 7;

	// ************************************************************
	// Controller operations and registers
	// ************************************************************
	localparam logic [3:0] OP_READ_LO    = 4'h1;
	localparam logic [3:0] OP_READ_HI    = 4'h2;
	localparam logic [3:0] OP_READ_SPARE = 4'h3;
	localparam logic [3:0] OP_RD_BYTE    = 4'h4;
	localparam logic [3:0] OP_PROG_LOAD  = 4'h5;
	localparam logic [3:0] OP_WR_BYTE    = 4'h6;
	localparam logic [3:0] OP_PROG_EXEC  = 4'h7;
	localparam logic [3:0] OP_ERASE      = 4'h8;
	localparam logic [3:0] OP_RESET      = 4'h9;
	localparam logic [3:0] OP_STATUS     = 4'hA;
	localparam logic [3:0] OP_ID         = 4'hB;
	localparam logic [3:0] OP_DESELECT   = 4'hC;

	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_ADDR   = 8'h04;
	localparam logic [7:0] REG_DATA   = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_ID     = 8'h10;

	localparam int CTRL_WP_BIT      = 8;
	localparam int STS_RUN_BIT      = 0;
	localparam int STS_RDY_BIT      = 1;
	localparam int STS_REFUSED_BIT  = 2;
	localparam int STS_FAIL_BIT     = 3;
	localparam int STS_SEL_BIT      = 4;
	localparam int STS_BYTE_LSB     = 8;

	localparam logic [7:0]  STATUS_RST = 8'h00;
	localparam logic [23:0] ADDR_RST   = 24'h00_0000;

	// ************************************************************
	// Step and pin cycle types
	// ************************************************************
	typedef enum logic [2:0] {
		ACT_CMD, ACT_ADR, ACT_DIN, ACT_DOUT, ACT_WAIT, ACT_WRDY
	} nfc_act_e;

	typedef enum logic [2:0] {
		SEL_K, SEL_COL, SEL_PG0, SEL_PG1, SEL_DATA
	} nfc_sel_e;

	typedef struct packed {
		nfc_act_e   act;
		nfc_sel_e   sel;
		logic [7:0] k;
		logic       last;
	} nfc_step_s;

endpackage : nfc_pkg

// ### hw/nfc_cyc_if.sv
// Handshake between the operation sequencer and the pin cycle engine
`timescale 1ns/10ps
interface nfc_cyc_if;
	logic              req;
	nfc_pkg::nfc_act_e kind;
	logic [7:0]        wdata;
	logic              done;
	logic [7:0]        rdata;

	modport seq (output req, kind, wdata, input done, rdata);
	modport eng (input req, kind, wdata, output done, rdata);
endinterface : nfc_cyc_if

// ### hw/nfc_pin_cyc.sv
// Pin cycle engine: one command, address, data-in or data-out cycle
`timescale 1ns/10ps
module nfc_pin_cyc (
	input  wire logic       clk_sys,
	input  wire logic       rst_b,
	input  wire logic       clk_en,
	nfc_cyc_if.eng          cyc,
	input  wire logic [7:0] io_in,
	output logic            cmd_latch,
	output logic            addr_latch,
	output logic            write_strobe_n,
	output logic            output_strobe_n,
	output logic [7:0]      io_out,
	output logic            io_oe
);

	typedef enum logic [1:0] {E_IDLE, E_SETUP, E_LOW, E_HIGH} nfc_est_e;

	nfc_est_e          st_ff;
	nfc_pkg::nfc_act_e kind_ff;
	logic [3:0]        cnt_ff;
	logic [7:0]        io_s1_ff;
	logic [7:0]        io_s2_ff;
	logic              done_ff;
	logic [7:0]        rdata_ff;
	logic              is_rd;

	assign is_rd     = (kind_ff == nfc_pkg::ACT_DOUT);
	assign cyc.done  = done_ff;
	assign cyc.rdata = rdata_ff;

	// ************************************************************
	// Input synchroniser
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			io_s1_ff <= 8'h00;
			io_s2_ff <= 8'h00;
		end else if (clk_en) begin
			io_s1_ff <= io_in;
			io_s2_ff <= io_s1_ff;
		end
	end

	// ************************************************************
	// Cycle sequence
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_ff           <= E_IDLE;
			kind_ff         <= nfc_pkg::ACT_CMD;
			cnt_ff          <= 4'h0;
			cmd_latch       <= 1'b0;
			addr_latch      <= 1'b0;
			write_strobe_n  <= 1'b1;
			output_strobe_n <= 1'b1;
			io_out          <= 8'h00;
			io_oe           <= 1'b0;
			done_ff         <= 1'b0;
			rdata_ff        <= 8'h00;
		end else if (clk_en) begin
			done_ff <= 1'b0;
			unique case (st_ff)
				E_IDLE: begin
					if (cyc.req) begin
						kind_ff    <= cyc.kind;
						// Both latches low marks a data cycle
						cmd_latch  <= (cyc.kind == nfc_pkg::ACT_CMD);
						addr_latch <= (cyc.kind == nfc_pkg::ACT_ADR);
						io_out     <= cyc.wdata;
						io_oe      <= (cyc.kind != nfc_pkg::ACT_DOUT);
						cnt_ff     <= nfc_pkg::SETUP_CYC - 4'h1;
						st_ff      <= E_SETUP;
					end
				end
				E_SETUP: begin
					if (cnt_ff == 4'h0) begin
						if (is_rd) begin
							output_strobe_n <= 1'b0;
							cnt_ff <= nfc_pkg::RLOW_CYC - 4'h1;
						end else begin
							write_strobe_n <= 1'b0;
							cnt_ff <= nfc_pkg::WLOW_CYC - 4'h1;
						end
						st_ff <= E_LOW;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				E_LOW: begin
					if (cnt_ff == 4'h0) begin
						// Low time covers access plus synchroniser delay
						if (is_rd) begin
							rdata_ff <= io_s2_ff;
						end
						write_strobe_n  <= 1'b1;
						output_strobe_n <= 1'b1;
						cnt_ff <= nfc_pkg::HOLD_CYC - 4'h1;
						st_ff  <= E_HIGH;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
				E_HIGH: begin
					if (cnt_ff == 4'h0) begin
						cmd_latch  <= 1'b0;
						addr_latch <= 1'b0;
						io_oe      <= 1'b0;
						done_ff    <= 1'b1;
						st_ff      <= E_IDLE;
					end else begin
						cnt_ff <= cnt_ff - 4'h1;
					end
				end
			endcase
		end
	end

endmodule : nfc_pin_cyc

// ### hw/nfc_host_ctrl.sv
// NAND flash host controller: register port, operation sequencer, pins
// Contract
// - Latch strobes pick command, address or data cycle; select stays low.
// - Address goes column byte, then two page bytes; bit 8 implied.
// - Keep chip select low from third read address through busy.
// - Trust the pass/fail bit only when the ready bit is set.
// - While busy, issue only status read 70 or reset FF.
// - Use status read to tell which of wire-tied devices is busy.
`timescale 1ns/10ps
module nfc_host_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        rst_b,
	input  wire logic        clk_en,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             cmd_latch,
	output logic             addr_latch,
	output logic             chip_sel_n,
	output logic             write_strobe_n,
	output logic             output_strobe_n,
	output logic             write_protect_n,
	input  wire logic [7:0]  io_in,
	output logic      [7:0]  io_out,
	output logic             io_oe,
	input  wire logic        busy_flag_n
);

	typedef enum logic [2:0] {
		M_IDLE, M_FETCH, M_CYC, M_WB, M_RDY
	} nfc_mst_e;

	nfc_cyc_if cyc ();

	nfc_mst_e           st_ff;
	logic [3:0]         op_ff;
	logic [2:0]         idx_ff;
	logic [3:0]         cnt_ff;
	logic               req_ff;
	nfc_pkg::nfc_act_e  kind_ff;
	logic [7:0]         wdata_ff;
	logic [23:0]        addr_ff;
	logic [7:0]         data_wr_ff;
	logic [7:0]         data_rd_ff;
	logic [7:0]         stat_ff;
	logic [15:0]        id_ff;
	logic               refused_ff;
	logic               rdy_s1_ff;
	logic               rdy_s2_ff;
	nfc_pkg::nfc_step_s step;
	logic [7:0]         step_byte;
	logic               ctrl_wr;
	logic [3:0]         new_op;
	logic               op_legal;
	logic               accept;
	logic               step_end;
	logic [31:0]        rd_mux;

	// ************************************************************
	// Operation step table
	// ************************************************************
	function automatic nfc_pkg::nfc_step_s mk(
		input nfc_pkg::nfc_act_e act,
		input nfc_pkg::nfc_sel_e sel,
		input logic [7:0]        k,
		input logic              last
	);
		nfc_pkg::nfc_step_s s;
		s.act  = act;
		s.sel  = sel;
		s.k    = k;
		s.last = last;
		return s;
	endfunction : mk

	function automatic nfc_pkg::nfc_step_s step_of(
		input logic [3:0] op,
		input logic [2:0] idx
	);
		nfc_pkg::nfc_step_s s;
		logic [7:0]         rd_cmd;
		s = mk(nfc_pkg::ACT_WRDY, nfc_pkg::SEL_K, 8'h00, 1'b1);
		rd_cmd = (op == nfc_pkg::OP_READ_HI) ? nfc_pkg::CMD_READ_HI :
			(op == nfc_pkg::OP_READ_SPARE) ? nfc_pkg::CMD_READ_SPARE :
			nfc_pkg::CMD_READ_LO;
		unique case (op)
			nfc_pkg::OP_READ_LO, nfc_pkg::OP_READ_HI,
			nfc_pkg::OP_READ_SPARE, nfc_pkg::OP_PROG_LOAD: begin
				// Column, then two page bytes; bit 8 rides on the command
				unique case (idx)
					3'd0: s = mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
						(op == nfc_pkg::OP_PROG_LOAD) ?
						nfc_pkg::CMD_SER_IN : rd_cmd, 1'b0);
					3'd1: s = mk(nfc_pkg::ACT_ADR, nfc_pkg::SEL_COL,
						8'h00, 1'b0);
					3'd2: s = mk(nfc_pkg::ACT_ADR, nfc_pkg::SEL_PG0,
						8'h00, 1'b0);
					3'd3: s = mk(nfc_pkg::ACT_ADR, nfc_pkg::SEL_PG1, 8'h00,
						op == nfc_pkg::OP_PROG_LOAD);
					default: s = mk(nfc_pkg::ACT_WAIT, nfc_pkg::SEL_K,
						8'h00, 1'b1);
				endcase
			end
			nfc_pkg::OP_RD_BYTE: begin
				// Next page transfer may be under way at a page end
				if (idx != 3'd0) begin
					s = mk(nfc_pkg::ACT_DOUT, nfc_pkg::SEL_K, 8'h00, 1'b1);
				end else begin
					s = mk(nfc_pkg::ACT_WRDY, nfc_pkg::SEL_K, 8'h00, 1'b0);
				end
			end
			nfc_pkg::OP_WR_BYTE:
				s = mk(nfc_pkg::ACT_DIN, nfc_pkg::SEL_DATA, 8'h00, 1'b1);
			nfc_pkg::OP_PROG_EXEC, nfc_pkg::OP_ERASE: begin
				unique case (idx)
					3'd0: s = mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
						(op == nfc_pkg::OP_ERASE) ? nfc_pkg::CMD_ERASE_SET :
						nfc_pkg::CMD_PROG_GO, 1'b0);
					3'd1: s = (op == nfc_pkg::OP_ERASE) ?
						mk(nfc_pkg::ACT_ADR, nfc_pkg::SEL_PG0, 8'h00, 1'b0) :
						mk(nfc_pkg::ACT_WAIT, nfc_pkg::SEL_K, 8'h00, 1'b0);
					3'd2: s = (op == nfc_pkg::OP_ERASE) ?
						mk(nfc_pkg::ACT_ADR, nfc_pkg::SEL_PG1, 8'h00, 1'b0) :
						mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
						nfc_pkg::CMD_STATUS, 1'b0);
					3'd3: s = (op == nfc_pkg::OP_ERASE) ?
						mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
						nfc_pkg::CMD_ERASE_GO, 1'b0) :
						mk(nfc_pkg::ACT_DOUT, nfc_pkg::SEL_K, 8'h00, 1'b1);
					3'd4: s = mk(nfc_pkg::ACT_WAIT, nfc_pkg::SEL_K,
						8'h00, 1'b0);
					3'd5: s = mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
						nfc_pkg::CMD_STATUS, 1'b0);
					default: s = mk(nfc_pkg::ACT_DOUT, nfc_pkg::SEL_K,
						8'h00, 1'b1);
				endcase
			end
			nfc_pkg::OP_RESET:
				s = (idx == 3'd0) ? mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
					nfc_pkg::CMD_RESET, 1'b0) :
					mk(nfc_pkg::ACT_WAIT, nfc_pkg::SEL_K, 8'h00, 1'b1);
			nfc_pkg::OP_STATUS:
				// Polled per device where ready lines are wire-tied
				s = (idx == 3'd0) ? mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
					nfc_pkg::CMD_STATUS, 1'b0) :
					mk(nfc_pkg::ACT_DOUT, nfc_pkg::SEL_K, 8'h00, 1'b1);
			nfc_pkg::OP_ID: begin
				unique case (idx)
					3'd0: s = mk(nfc_pkg::ACT_CMD, nfc_pkg::SEL_K,
						nfc_pkg::CMD_ID, 1'b0);
					3'd1: s = mk(nfc_pkg::ACT_ADR, nfc_pkg::SEL_K,
						nfc_pkg::ID_ADDR, 1'b0);
					default: s = mk(nfc_pkg::ACT_DOUT, nfc_pkg::SEL_K,
						8'h00, idx == 3'd3);
				endcase
			end
			default: s = mk(nfc_pkg::ACT_WRDY, nfc_pkg::SEL_K, 8'h00, 1'b1);
		endcase
		return s;
	endfunction : step_of

	assign step = step_of(op_ff, idx_ff);

	always_comb begin
		unique case (step.sel)
			nfc_pkg::SEL_COL:  step_byte = addr_ff[7:0];
			nfc_pkg::SEL_PG0:  step_byte = addr_ff[15:8];
			nfc_pkg::SEL_PG1:  step_byte = addr_ff[23:16];
			nfc_pkg::SEL_DATA: step_byte = data_wr_ff;
			default:           step_byte = step.k;
		endcase
	end

	// ************************************************************
	// Busy flag synchroniser
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rdy_s1_ff <= 1'b0;
			rdy_s2_ff <= 1'b0;
		end else if (clk_en) begin
			rdy_s1_ff <= busy_flag_n;
			rdy_s2_ff <= rdy_s1_ff;
		end
	end

	// ************************************************************
	// Operation acceptance
	// ************************************************************
	assign ctrl_wr  = reg_wr && (reg_addr == nfc_pkg::REG_CTRL);
	assign new_op   = reg_wdata[3:0];
	assign op_legal = (new_op >= nfc_pkg::OP_READ_LO) &&
		(new_op <= nfc_pkg::OP_DESELECT);
	// Busy device takes only status or reset; reset may also abort a wait
	assign accept = ctrl_wr && op_legal &&
		((st_ff == M_IDLE && (rdy_s2_ff || new_op == nfc_pkg::OP_STATUS ||
		new_op == nfc_pkg::OP_RESET)) || (new_op == nfc_pkg::OP_RESET &&
		(st_ff == M_WB || st_ff == M_RDY)));
	assign step_end = (st_ff == M_CYC && cyc.done) ||
		(st_ff == M_RDY && rdy_s2_ff);

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			refused_ff <= 1'b0;
		end else if (clk_en) begin
			if (ctrl_wr && !accept) begin
				refused_ff <= 1'b1;
			end else if (reg_wr && reg_addr == nfc_pkg::REG_STATUS &&
				reg_wdata[nfc_pkg::STS_REFUSED_BIT]) begin
				refused_ff <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			st_ff    <= M_IDLE;
			op_ff    <= 4'h0;
			idx_ff   <= 3'd0;
			cnt_ff   <= 4'h0;
			req_ff   <= 1'b0;
			kind_ff  <= nfc_pkg::ACT_CMD;
			wdata_ff <= 8'h00;
		end else if (clk_en) begin
			req_ff <= 1'b0;
			if (accept && new_op != nfc_pkg::OP_DESELECT) begin
				op_ff  <= new_op;
				idx_ff <= 3'd0;
				st_ff  <= M_FETCH;
			end else begin
				unique case (st_ff)
					M_IDLE: ;
					M_FETCH: begin
						if (step.act == nfc_pkg::ACT_WAIT) begin
							// Busy shows only some time after the strobe
							cnt_ff <= nfc_pkg::WB_CYC - 4'h1;
							st_ff  <= M_WB;
						end else if (step.act == nfc_pkg::ACT_WRDY) begin
							st_ff <= M_RDY;
						end else begin
							req_ff   <= 1'b1;
							kind_ff  <= step.act;
							wdata_ff <= step_byte;
							st_ff    <= M_CYC;
						end
					end
					M_WB: begin
						if (cnt_ff == 4'h0) begin
							st_ff <= M_RDY;
						end else begin
							cnt_ff <= cnt_ff - 4'h1;
						end
					end
					M_CYC, M_RDY: begin
						if (step_end) begin
							idx_ff <= idx_ff + 3'd1;
							st_ff  <= step.last ? M_IDLE : M_FETCH;
						end
					end
				endcase
			end
		end
	end

	assign cyc.req   = req_ff;
	assign cyc.kind  = kind_ff;
	assign cyc.wdata = wdata_ff;

	// ************************************************************
	// Chip select and captured read data
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			chip_sel_n <= 1'b1;
		end else if (clk_en && accept) begin
			// Deselect is refused while busy, so a read transfer completes
			chip_sel_n <= (new_op == nfc_pkg::OP_DESELECT);
		end
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			data_rd_ff <= 8'h00;
			stat_ff    <= nfc_pkg::STATUS_RST;
			id_ff      <= 16'h0000;
		end else if (clk_en && st_ff == M_CYC && cyc.done &&
			step.act == nfc_pkg::ACT_DOUT) begin
			if (op_ff == nfc_pkg::OP_RD_BYTE) begin
				data_rd_ff <= cyc.rdata;
			end else if (op_ff == nfc_pkg::OP_ID) begin
				if (idx_ff == 3'd2) begin
					id_ff[7:0] <= cyc.rdata;
				end else begin
					id_ff[15:8] <= cyc.rdata;
				end
			end else begin
				stat_ff <= cyc.rdata;
			end
		end
	end

	// ************************************************************
	// Register port
	// ************************************************************
	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			addr_ff         <= nfc_pkg::ADDR_RST;
			data_wr_ff      <= 8'h00;
			write_protect_n <= 1'b0;
		end else if (clk_en && reg_wr) begin
			unique case (reg_addr)
				nfc_pkg::REG_CTRL:
					write_protect_n <= reg_wdata[nfc_pkg::CTRL_WP_BIT];
				nfc_pkg::REG_ADDR: addr_ff    <= reg_wdata[23:0];
				nfc_pkg::REG_DATA: data_wr_ff <= reg_wdata[7:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (reg_addr)
			nfc_pkg::REG_CTRL: begin
				rd_mux[3:0] = op_ff;
				rd_mux[nfc_pkg::CTRL_WP_BIT] = write_protect_n;
			end
			nfc_pkg::REG_ADDR: rd_mux[23:0] = addr_ff;
			nfc_pkg::REG_DATA: rd_mux[7:0]  = data_rd_ff;
			nfc_pkg::REG_STATUS: begin
				rd_mux[nfc_pkg::STS_RUN_BIT]     = (st_ff != M_IDLE);
				rd_mux[nfc_pkg::STS_RDY_BIT]     = rdy_s2_ff;
				rd_mux[nfc_pkg::STS_REFUSED_BIT] = refused_ff;
				// Fail counts only when the same byte says ready
				rd_mux[nfc_pkg::STS_FAIL_BIT] =
					stat_ff[nfc_pkg::ST_FAIL_BIT] &
					stat_ff[nfc_pkg::ST_READY_BIT];
				rd_mux[nfc_pkg::STS_SEL_BIT] = ~chip_sel_n;
				rd_mux[15:8] = stat_ff;
			end
			nfc_pkg::REG_ID: rd_mux[15:0] = id_ff;
			default: ;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0000_0000;
		end else if (clk_en) begin
			reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
		end
	end

	nfc_pin_cyc u_pin_cyc (
		.clk_sys         (clk_sys),
		.rst_b           (rst_b),
		.clk_en          (clk_en),
		.cyc             (cyc.eng),
		.io_in           (io_in),
		.cmd_latch       (cmd_latch),
		.addr_latch      (addr_latch),
		.write_strobe_n  (write_strobe_n),
		.output_strobe_n (output_strobe_n),
		.io_out          (io_out),
		.io_oe           (io_oe)
	);

endmodule : nfc_host_ctrl

// ### tb/nfc_host_ctrl_sva.sv
// Pin and register port properties of the NAND host controller
`timescale 1ns/10ps
module nfc_host_ctrl_sva (
	input logic        clk_sys,
	input logic        rst_b,
	input logic        reg_rd,
	input logic [7:0]  reg_addr,
	input logic [31:0] reg_rdata,
	input logic        cmd_latch,
	input logic        addr_latch,
	input logic        chip_sel_n,
	input logic        write_strobe_n,
	input logic        output_strobe_n,
	input logic        write_protect_n,
	input logic [7:0]  io_out,
	input logic        io_oe,
	input logic        busy_flag_n
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_b);
	sequence s_re_low;
		!output_strobe_n [*4] ##1 output_strobe_n;
	endsequence
	// Busy long enough that the controller has surely seen it
	sequence s_busy_cmd;
		!busy_flag_n [*4] ##0 (cmd_latch && !write_strobe_n);
	endsequence
	a_latch_excl: assert property (!(cmd_latch && addr_latch))
		else $error("both latches high");
	a_sel_cycle: assert property (
		(cmd_latch || addr_latch || !write_strobe_n) |-> !chip_sel_n)
		else $error("cycle without select");
	a_cmd_drive: assert property ($fell(write_strobe_n) |->
		io_oe ##1 (write_strobe_n && io_oe))
		else $error("write pulse wrong");
	a_read_hiz: assert property (!output_strobe_n |-> !io_oe)
		else $error("driving during read");
	a_read_pulse: assert property ($fell(output_strobe_n) |-> s_re_low)
		else $error("read pulse length");
	a_data_wp: assert property (
		(!cmd_latch && !addr_latch && $fell(write_strobe_n)) |->
		write_protect_n) else $error("data with protect low");
	a_busy_cmd: assert property (s_busy_cmd |->
		io_out inside {nfc_pkg::CMD_STATUS, nfc_pkg::CMD_RESET})
		else $error("command while busy");
	a_cs_busy: assert property (!busy_flag_n |-> !chip_sel_n)
		else $error("select released while busy");
	a_fail_ready: assert property (($past(reg_rd) &&
		$past(reg_addr) == nfc_pkg::REG_STATUS && reg_rdata[3]) |->
		reg_rdata[14]) else $error("fail without ready");
endmodule : nfc_host_ctrl_sva

// ### tb/nfc_flash_model.sv
// Behavioural byte-wide NAND flash at the controller's pins
`timescale 1ns/10ps
module nfc_flash_model #(
	parameter logic [7:0] MAKER  = 8'h5A,
	parameter logic [7:0] DEVICE = 8'hC3
) (
	input  logic       cmd_latch,
	input  logic       addr_latch,
	input  logic       chip_sel_n,
	input  logic       write_strobe_n,
	input  logic       output_strobe_n,
	input  logic       write_protect_n,
	input  logic [7:0] din,
	output logic [7:0] dout,
	output logic       busy_flag_n
);
	int         bt = 0;
	int         ptr = 0;
	int         base = 0;
	int         na = 0;
	logic [7:0] cmd = 8'h00, pg = 8'h00, q = 8'h00, last = 8'h00;
	logic       fail = 1'h0, setup = 1'h0;
	// Own 50 ns tick; busy length is short, not the real array time
	always #50 if (bt > 0) bt = bt - 1;
	assign busy_flag_n = (bt == 0);
	// Released lines show the inverse so stale data cannot pass
	assign dout = output_strobe_n ? ~q : q;
	always @(posedge write_strobe_n) if (!chip_sel_n) begin
		if (cmd_latch) begin
			cmd = din;
			na = 0;
			case (din)
			8'h00: base = 0;
			8'h01: base = 256;
			8'h50: base = 512;
			8'h10: begin
				fail = last[0];
				bt = 200;
			end
			8'hD0: if (setup) begin
				fail = 1'h0;
				bt = 200;
			end
			8'hFF: bt = (bt > 0) ? 2 : 0;
			default: ;
			endcase
			setup = (din == 8'h60);
		end else if (addr_latch) begin
			na = na + 1;
			if (na == 1) ptr = base + din;
			if (na == 2) pg = din;
			if (na == 3 && cmd != 8'h80) bt = 200;
		end else last = din;
	end
	always @(negedge output_strobe_n) begin
		if (cmd == 8'h70)
			q = {write_protect_n, busy_flag_n, 5'h00, fail};
		else if (cmd == 8'h90) begin
			q = (na == 1) ? MAKER : DEVICE;
			na = 2;
		end else begin
			q = 8'(ptr) ^ {ptr[9:8], 6'h00} ^ pg;
			if (ptr < 527) ptr = ptr + 1;
		end
	end
endmodule : nfc_flash_model

// ### tb/test_nfc_host_ctrl.sv
// Self-checking bench for the NAND host controller
`timescale 1ns/10ps
module test_nfc_host_ctrl;
	localparam logic [7:0] MAKER  = 8'h5A; // Arbitrary value
	localparam logic [7:0] DEVICE = 8'hC3; // Arbitrary value
	logic        clk_sys = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [7:0]  reg_addr = 8'h00, col, dat;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
	logic [15:0] pg;
	wire         cl, al, cs_n, we_n, re_n, wp_n, oe, bsy_n;
	wire  [7:0]  io_o, io_i, m_io;
	int          miscompares = 0, comparisons = 0, seed = 97462, cyc = 0;
	int          i, k, t;
	assign io_i = oe ? io_o : m_io;
	always #25 clk_sys = ~clk_sys;
	nfc_host_ctrl u_dut (.clk_sys, .rst_b, .clk_en(1'h1), .reg_addr,
		.reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cmd_latch(cl),
		.addr_latch(al), .chip_sel_n(cs_n), .write_strobe_n(we_n),
		.output_strobe_n(re_n), .write_protect_n(wp_n), .io_in(io_i),
		.io_out(io_o), .io_oe(oe), .busy_flag_n(bsy_n));
	nfc_flash_model #(.MAKER(MAKER), .DEVICE(DEVICE)) u_flash (
		.cmd_latch(cl), .addr_latch(al), .chip_sel_n(cs_n),
		.write_strobe_n(we_n), .output_strobe_n(re_n),
		.write_protect_n(wp_n), .din(io_o), .dout(m_io),
		.busy_flag_n(bsy_n));
	// ************************************************************
	// Bus tasks and checks
	// ************************************************************
	function automatic logic [7:0] fx(input int p, input logic [7:0] g);
		return 8'(p) ^ {p[9:8], 6'h00} ^ g;
	endfunction : fx
	task chk(input logic [31:0] s, input logic [31:0] e, input string n);
		comparisons++;
		if (s !== e) begin
			miscompares++;
			$display("[ERR] %s expected %0h seen %0h", n, e, s);
		end
	endtask : chk
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'h1;
		@(posedge clk_sys);
		reg_wr <= 1'h0;
	endtask : wr
	task rd(input logic [7:0] a);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'h1;
		@(posedge clk_sys);
		reg_rd <= 1'h0;
		@(negedge clk_sys);
		rv = reg_rdata;
	endtask : rd
	// Polls the running flag; a stuck op ends as a mismatch
	task op(input logic [3:0] c, input logic w = 1'h1);
		int n;
		wr(nfc_pkg::REG_CTRL, {23'h0, w, 4'h0, c});
		for (n = 0; n < 900; n++) begin
			rd(nfc_pkg::REG_STATUS);
			if (rv[0] === 1'h0) break;
		end
		chk(rv[0], 1'h0, "op end");
	endtask : op
	task report_and_stop;
		$display("comparisons %0d mismatches %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : report_and_stop
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			miscompares++;
			report_and_stop;
		end
	end
	initial begin
		repeat (12) @(posedge clk_sys);
		chk({cl, al, cs_n, we_n, re_n, wp_n, oe}, 7'h1C, "reset pins");
		rst_b <= 1'h1;
		repeat (4) @(posedge clk_sys);
		rd(8'h14);
		chk(rv, 32'h0, "unmapped");
		for (k = 0; k < 3; k++) begin
			col = (k == 2) ? 8'h0E : 8'($random(seed));
			pg = 16'($random(seed));
			wr(nfc_pkg::REG_ADDR, {8'h00, pg, col});
			op(nfc_pkg::OP_READ_LO + 4'(k));
			for (i = 0; i < 3; i++) begin
				op(nfc_pkg::OP_RD_BYTE);
				rd(nfc_pkg::REG_DATA);
				t = k * 256 + col + i;
				chk(rv[7:0], fx(t > 527 ? 527 : t, pg[7:0]), "data");
			end
		end
		$display("read modes done");
		for (k = 0; k < 2; k++) begin
			op(nfc_pkg::OP_STATUS, k[0]);
			rd(nfc_pkg::REG_STATUS);
			chk(rv[15:8], {k[0], 7'h40}, "status byte");
		end
		op(nfc_pkg::OP_ID);
		rd(nfc_pkg::REG_ID);
		chk(rv[15:0], {DEVICE, MAKER}, "id bytes");
		$display("status and id done");
		dat = 8'($random(seed));
		wr(nfc_pkg::REG_ADDR, {8'h00, 24'($random(seed))});
		op(nfc_pkg::OP_PROG_LOAD);
		wr(nfc_pkg::REG_DATA, {24'h0, dat});
		op(nfc_pkg::OP_WR_BYTE);
		op(nfc_pkg::OP_PROG_EXEC);
		rd(nfc_pkg::REG_STATUS);
		chk(rv[15:8], {7'h60, dat[0]}, "program status");
		chk(rv[3], dat[0], "fail flag");
		op(nfc_pkg::OP_ERASE);
		rd(nfc_pkg::REG_STATUS);
		chk(rv[15:8], 8'hC0, "erase status");
		$display("program and erase done");
		wr(nfc_pkg::REG_CTRL, 32'h101);
		wr(nfc_pkg::REG_CTRL, 32'h10A);
		for (i = 0; i < 99 && bsy_n; i++) @(posedge clk_sys);
		// Reset is taken only once the sequencer sits in its busy wait
		repeat (2) @(posedge clk_sys);
		t = cyc;
		op(nfc_pkg::OP_RESET);
		chk(cyc - t < 90, 1'h1, "abort time");
		rd(nfc_pkg::REG_STATUS);
		chk(rv[2:1], 2'h3, "refused flag");
		chk(rv[4], 1'h1, "selected");
		op(nfc_pkg::OP_DESELECT);
		rd(nfc_pkg::REG_STATUS);
		chk(rv[4], 1'h0, "deselected");
		$display("abort done");
		report_and_stop;
	end
endmodule : test_nfc_host_ctrl
bind nfc_host_ctrl nfc_host_ctrl_sva u_sva (.clk_sys, .rst_b, .reg_rd,
	.reg_addr, .reg_rdata, .cmd_latch, .addr_latch, .chip_sel_n,
	.write_strobe_n, .output_strobe_n, .write_protect_n, .io_out, .io_oe,
	.busy_flag_n);
